//--- rtl/dcsc_pkg.sv
// dcsc_pkg: register map, field layout, reset values and timing for the config-select control
package dcsc_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [11:0] ADDR_DEVICE_CONFIGURATION = 12'h000;
    localparam logic [11:0] ADDR_SELECT_STATUS        = 12'h004;
    localparam logic [11:0] ADDR_SYNC_CONTROL         = 12'h008;

    // ---------------------------------------------------------------
    // device_configuration fields
    // ---------------------------------------------------------------
    localparam int DYN_DEB_POS   = 22;
    localparam int REF_DEB_POS   = 20;
    localparam int SYNC_WAIT_POS = 16;
    localparam int PG_SEL_POS    = 12;
    localparam int SUP3_POS      = 11;
    localparam int SUP2_POS      = 10;
    localparam int SSEL2_POS     = 4;
    localparam int SSEL1_POS     = 2;
    localparam int SSEL0_POS     = 0;

    localparam logic [31:0] CFG_RW_MASK = 32'h7FFF_FFFF;

    localparam logic [1:0] REF_DEB_RST   = 2'h1;
    localparam logic [3:0] SYNC_WAIT_RST = 4'h2;
    localparam logic [3:0] PG_SEL_RST    = 4'hF;
    localparam logic [1:0] SSEL_RST      = 2'h2;
    localparam logic [31:0] CFG_RST = (32'(REF_DEB_RST) << REF_DEB_POS)
                                    | (32'(SYNC_WAIT_RST) << SYNC_WAIT_POS)
                                    | (32'(PG_SEL_RST) << PG_SEL_POS)
                                    | (32'(SSEL_RST) << SSEL2_POS)
                                    | (32'(SSEL_RST) << SSEL1_POS)
                                    | (32'(SSEL_RST) << SSEL0_POS);

    // ---------------------------------------------------------------
    // codes
    // ---------------------------------------------------------------
    localparam logic [3:0] PG_SEL_OFF     = 4'hF;
    localparam logic [3:0] PG_SEL_GPI_LO  = 4'h5;
    localparam logic [3:0] PG_SEL_GPI_HI  = 4'h8;
    localparam logic [3:0] SYNC_WAIT_MAX  = 4'hC;
    localparam logic [1:0] SSEL_LOW       = 2'h0;
    localparam logic [1:0] SSEL_MID       = 2'h1;
    localparam logic [1:0] SSEL_PIN       = 2'h2;
    localparam logic [1:0] SSEL_HIGH      = 2'h3;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int DYN_DEB_SHORT = 8;
    localparam int DYN_DEB_LONG  = 256;
    localparam int CLK_MHZ       = 100;
    localparam int SYNC_UNIT_US  = 1;
    localparam int SYNC_UNIT_CYC = SYNC_UNIT_US * CLK_MHZ;

    typedef enum logic [1:0] { DCSC_IDLE, DCSC_DISABLE, DCSC_SYNC } dcsc_sync_t;
    typedef enum logic [1:0] { DCSC_PG_WAIT, DCSC_LOAD, DCSC_RUN } dcsc_boot_t;

    // tri-level encoding on the static select bits
    typedef struct packed {
        logic [1:0] bit2;
        logic [1:0] bit1;
        logic [1:0] bit0;
    } dcsc_static_t;
endpackage

//--- rtl/dcsc_top.sv
// dcsc_top: config-select debounce, sync wait timer, power-good gate, static select sourcing
// ---------------------------------------------------------------
// Functional notes
// - dynamic select applied after 8 or 256 stable cycles per debounce bit
// - reference select applied after 2, 4, 6 or 8 stable cycles
// - sync: drop output enable, wait interval, then stop clocks and sync
// - sync wait code n means 2 to the n microseconds, up to 4096
// - with a power-good pin chosen, load user config only once it is high
// - power-good select: 0-4 general pins, 5-8 input pins, 0xF disabled
// - static source code 0 low, 1 mid, 3 high, 2 samples the pin
// - static bit 2,1,0 fields at 5:4, 3:2, 1:0, pins 2,1,0
// - reset values: ref debounce 1, wait 2, power-good 0xF, static 2
// ---------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module dcsc_top #(
    parameter int DYN_WIDTH  = 4,
    parameter int SYNC_SCALE = dcsc_pkg::SYNC_UNIT_CYC
) (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    // axi4-lite slave
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // pins
    input  wire logic [4:0]           gpioIn,
    input  wire logic [3:0]           gpiIn,
    input  wire logic [DYN_WIDTH-1:0] dynSelectIn,
    input  wire logic [1:0]           refSelectIn,
    input  wire logic [5:0]           staticPinLevel,
    // load handshake in; select, sync, load and supply outputs
    input  wire logic                 loadDone,
    output logic [DYN_WIDTH-1:0]      dynSelect,
    output logic [1:0]                refSelect,
    output logic                      syncOutputEnable,
    output logic                      syncStopClocks,
    output logic                      loadUserConfig,
    output logic                      userConfigReady,
    output logic [5:0]                staticSelect,
    output logic                      inputSupply2Float,
    output logic                      inputSupply3Float
);
    typedef struct packed {
        logic [31:0]            cfg;
        logic                   awHeld;
        logic [11:0]            awAddr;
        logic                   wHeld;
        logic [31:0]            wData;
        logic [3:0]             wStrb;
        logic                   bValid;
        logic [1:0]             bResp;
        logic                   rValid;
        logic [31:0]            rData;
        logic [1:0]             rResp;
        logic [DYN_WIDTH-1:0]   dynSample;
        logic [DYN_WIDTH-1:0]   dynApplied;
        logic [8:0]             dynCount;
        logic [1:0]             refSample;
        logic [1:0]             refApplied;
        logic [3:0]             refCount;
        dcsc_pkg::dcsc_sync_t   syncState;
        logic [31:0]            syncCount;
        dcsc_pkg::dcsc_boot_t   bootState;
        dcsc_pkg::dcsc_static_t staticLatch;
        logic                   cfgWritten;
    } dcsc_state_t;

    dcsc_state_t stReg;
    dcsc_state_t stNext;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [1:0] static_source(input logic [1:0] code, input logic [1:0] pin);
        unique case (code)
            dcsc_pkg::SSEL_LOW:  static_source = 2'h0;
            dcsc_pkg::SSEL_MID:  static_source = 2'h1;
            dcsc_pkg::SSEL_PIN:  static_source = pin;
            dcsc_pkg::SSEL_HIGH: static_source = 2'h3;
        endcase
    endfunction

    function automatic logic [31:0] apply_strobe(input logic [31:0] old, input logic [31:0] data,
                                                 input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        apply_strobe = res;
    endfunction

    // ---------------------------------------------------------------
    // decoded fields
    // ---------------------------------------------------------------
    logic        dynDebLong;
    logic [1:0]  refDeb;
    logic [3:0]  syncWait;
    logic [3:0]  pgSel;
    logic [8:0]  dynTarget;
    logic [3:0]  refTarget;
    logic [31:0] syncTarget;
    logic        pgLevel;
    logic        pgEnabled;
    logic        syncStart;
    logic [31:0] selStatus;

    assign dynDebLong = stReg.cfg[dcsc_pkg::DYN_DEB_POS];
    assign refDeb     = stReg.cfg[dcsc_pkg::REF_DEB_POS +: 2];
    assign syncWait   = stReg.cfg[dcsc_pkg::SYNC_WAIT_POS +: 4];
    assign pgSel      = stReg.cfg[dcsc_pkg::PG_SEL_POS +: 4];
    assign dynTarget  = dynDebLong ? 9'(dcsc_pkg::DYN_DEB_LONG)
                                   : 9'(dcsc_pkg::DYN_DEB_SHORT);
    assign refTarget  = {1'b0, refDeb, 1'b0} + 4'h2;
    // codes above the top step saturate at the longest wait
    assign syncTarget = 32'(SYNC_SCALE) << ((syncWait > dcsc_pkg::SYNC_WAIT_MAX)
                        ? dcsc_pkg::SYNC_WAIT_MAX : syncWait);

    always_comb begin
        pgLevel   = 1'b1;
        pgEnabled = 1'b0;
        if (pgSel < dcsc_pkg::PG_SEL_GPI_LO) begin
            pgLevel   = gpioIn[pgSel[2:0]];
            pgEnabled = 1'b1;
        end else if (pgSel <= dcsc_pkg::PG_SEL_GPI_HI) begin
            pgLevel   = gpiIn[2'(pgSel - dcsc_pkg::PG_SEL_GPI_LO)];
            pgEnabled = 1'b1;
        end
    end

    assign selStatus = {14'h0000, 2'(stReg.syncState), 2'(stReg.bootState),
                        refSelect, 6'(stReg.staticLatch), 2'h0, 4'(stReg.dynApplied)};

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        stNext    = stReg;
        syncStart = 1'b0;

        // bus write: both halves held, then answered
        if (s_axi_awvalid && s_axi_awready) begin
            stNext.awHeld = 1'b1;
            stNext.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            stNext.wHeld = 1'b1;
            stNext.wData = s_axi_wdata;
            stNext.wStrb = s_axi_wstrb;
        end
        if (stReg.awHeld && stReg.wHeld && !stReg.bValid) begin
            stNext.awHeld = 1'b0;
            stNext.wHeld  = 1'b0;
            stNext.bValid = 1'b1;
            stNext.bResp  = 2'h0;
            unique case (stReg.awAddr)
                dcsc_pkg::ADDR_DEVICE_CONFIGURATION: begin
                    stNext.cfg = apply_strobe(stReg.cfg, stReg.wData, stReg.wStrb)
                                 & dcsc_pkg::CFG_RW_MASK;
                    stNext.cfgWritten = 1'b1;
                end
                dcsc_pkg::ADDR_SYNC_CONTROL: begin
                    syncStart = stReg.wStrb[0] & stReg.wData[0];
                end
                dcsc_pkg::ADDR_SELECT_STATUS: begin
                end
                default: stNext.bResp = 2'h2;
            endcase
        end
        if (stReg.bValid && s_axi_bready) begin
            stNext.bValid = 1'b0;
        end

        // bus read
        if (s_axi_arvalid && s_axi_arready) begin
            stNext.rValid = 1'b1;
            stNext.rResp  = 2'h0;
            unique case (s_axi_araddr)
                dcsc_pkg::ADDR_DEVICE_CONFIGURATION: stNext.rData = stReg.cfg;
                dcsc_pkg::ADDR_SELECT_STATUS:        stNext.rData = selStatus;
                dcsc_pkg::ADDR_SYNC_CONTROL: begin
                    stNext.rData = {31'h0, stReg.syncState != dcsc_pkg::DCSC_IDLE};
                end
                default: begin
                    stNext.rData = 32'h0000_0000;
                    stNext.rResp = 2'h2;
                end
            endcase
        end else if (stReg.rValid && s_axi_rready) begin
            stNext.rValid = 1'b0;
        end

        // dynamic select debounce
        stNext.dynSample = dynSelectIn;
        if (dynSelectIn != stReg.dynSample) begin
            stNext.dynCount = 9'h001;
        end else if (stReg.dynCount < dynTarget) begin
            stNext.dynCount = stReg.dynCount + 9'h001;
        end
        if (dynSelectIn == stReg.dynSample && stReg.dynCount + 9'h001 >= dynTarget) begin
            stNext.dynApplied = stReg.dynSample;
        end

        // reference select debounce
        stNext.refSample = refSelectIn;
        if (refSelectIn != stReg.refSample) begin
            stNext.refCount = 4'h1;
        end else if (stReg.refCount < refTarget) begin
            stNext.refCount = stReg.refCount + 4'h1;
        end
        if (refSelectIn == stReg.refSample && stReg.refCount + 4'h1 >= refTarget) begin
            stNext.refApplied = stReg.refSample;
        end

        // divider synchronization
        unique case (stReg.syncState)
            dcsc_pkg::DCSC_IDLE: begin
                if (syncStart) begin
                    stNext.syncState = dcsc_pkg::DCSC_DISABLE;
                    stNext.syncCount = 32'h0000_0001;
                end
            end
            dcsc_pkg::DCSC_DISABLE: begin
                stNext.syncCount = stReg.syncCount + 32'h0000_0001;
                if (stReg.syncCount >= syncTarget) begin
                    stNext.syncState = dcsc_pkg::DCSC_SYNC;
                end
            end
            dcsc_pkg::DCSC_SYNC: begin
                stNext.syncState = dcsc_pkg::DCSC_IDLE;
            end
            default: stNext.syncState = dcsc_pkg::DCSC_IDLE;
        endcase

        // power-up gate and static select latch
        unique case (stReg.bootState)
            dcsc_pkg::DCSC_PG_WAIT: begin
                // boot waits for the common configuration so its pg and static fields apply
                if (stReg.cfgWritten && (!pgEnabled || pgLevel)) begin
                    stNext.bootState          = dcsc_pkg::DCSC_LOAD;
                    stNext.staticLatch.bit2 = static_source(stReg.cfg[dcsc_pkg::SSEL2_POS +: 2],
                                                            staticPinLevel[5:4]);
                    stNext.staticLatch.bit1 = static_source(stReg.cfg[dcsc_pkg::SSEL1_POS +: 2],
                                                            staticPinLevel[3:2]);
                    stNext.staticLatch.bit0 = static_source(stReg.cfg[dcsc_pkg::SSEL0_POS +: 2],
                                                            staticPinLevel[1:0]);
                end
            end
            dcsc_pkg::DCSC_LOAD: begin
                if (loadDone) begin
                    stNext.bootState = dcsc_pkg::DCSC_RUN;
                end
            end
            dcsc_pkg::DCSC_RUN: begin
            end
            default: stNext.bootState = dcsc_pkg::DCSC_PG_WAIT;
        endcase

        if (sys_rst) begin
            stNext             = '0;
            stNext.cfg         = dcsc_pkg::CFG_RST;
            stNext.dynSample   = dynSelectIn;
            stNext.refSample   = refSelectIn;
            stNext.syncState   = dcsc_pkg::DCSC_IDLE;
            stNext.bootState   = dcsc_pkg::DCSC_PG_WAIT;
        end
    end

    always_ff @(posedge core_clk) begin
        stReg <= stNext;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // one write and one read at a time keeps the slave simple; throughput is not a concern here
    assign s_axi_awready     = !stReg.awHeld && !stReg.bValid;
    assign s_axi_wready      = !stReg.wHeld && !stReg.bValid;
    assign s_axi_bvalid      = stReg.bValid;
    assign s_axi_bresp       = stReg.bResp;
    assign s_axi_arready     = !stReg.rValid;
    assign s_axi_rvalid      = stReg.rValid;
    assign s_axi_rdata       = stReg.rData;
    assign s_axi_rresp       = stReg.rResp;
    assign dynSelect         = stReg.dynApplied;
    assign refSelect         = stReg.refApplied;
    assign syncOutputEnable  = stReg.syncState == dcsc_pkg::DCSC_IDLE;
    assign syncStopClocks    = stReg.syncState == dcsc_pkg::DCSC_SYNC;
    assign loadUserConfig    = stReg.bootState == dcsc_pkg::DCSC_LOAD;
    assign userConfigReady   = stReg.bootState == dcsc_pkg::DCSC_RUN;
    assign staticSelect      = stReg.staticLatch;
    assign inputSupply2Float = stReg.cfg[dcsc_pkg::SUP2_POS];
    assign inputSupply3Float = stReg.cfg[dcsc_pkg::SUP3_POS];
endmodule
`default_nettype wire

//--- tb/dcsc_board_model.sv
// dcsc_board_model: configuration memory answering the user config load
`timescale 1ns/10ps
`default_nettype none
module dcsc_board_model (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] loadLatency,
    input  wire logic       loadUserConfig,
    output logic            loadDone
);
    logic [7:0] waitCnt_reg;
    // done is a one-cycle pulse, repeated every 256 cycles while the load request stays high
    always_ff @(posedge core_clk) begin
        if (sys_rst || !loadUserConfig) begin
            waitCnt_reg <= 8'h00;
            loadDone    <= 1'b0;
        end else begin
            waitCnt_reg <= waitCnt_reg + 8'h01;
            loadDone    <= (waitCnt_reg == loadLatency);
        end
    end
endmodule
`default_nettype wire

//--- tb/dcsc_top_asserts.sv
// dcsc_top_asserts: port-level checks for dcsc_top
`timescale 1ns/10ps
`default_nettype none
module dcsc_top_asserts #(
    parameter int DYN_WIDTH = 4
) (
    input wire logic                 core_clk,
    input wire logic                 sys_rst,
    input wire logic [DYN_WIDTH-1:0] dynSelectIn,
    input wire logic [DYN_WIDTH-1:0] dynSelect,
    input wire logic [1:0]           refSelectIn,
    input wire logic [1:0]           refSelect,
    input wire logic                 syncOutputEnable,
    input wire logic                 syncStopClocks,
    input wire logic                 loadUserConfig,
    input wire logic                 loadDone,
    input wire logic                 userConfigReady,
    input wire logic [5:0]           staticSelect,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic [31:0]          s_axi_rdata
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_oe_low2;
        !syncOutputEnable && ($past(syncOutputEnable) == 1'b0);
    endsequence
    sequence s_load_done;
        loadUserConfig && loadDone;
    endsequence
    a_stop_after_wait: assert property (syncStopClocks |-> s_oe_low2)
        else $error("clock stop without prior output disable");
    a_stop_one_cycle: assert property (syncStopClocks |=> !syncStopClocks)
        else $error("clock stop longer than one cycle");
    a_dyn_settled: assert property ($changed(dynSelect) |->
        dynSelect == $past(dynSelectIn) && $past(dynSelectIn) == $past(dynSelectIn, 4))
        else $error("dynamic select applied before settling");
    a_ref_settled: assert property ($changed(refSelect) |-> refSelect == $past(refSelectIn))
        else $error("reference select applied before settling");
    a_load_release: assert property (s_load_done |=> !loadUserConfig && userConfigReady)
        else $error("load request not released on done");
    a_ready_kept: assert property (userConfigReady |=> userConfigReady)
        else $error("ready dropped without reset");
    a_static_latch: assert property ($changed(staticSelect) |-> $rose(loadUserConfig))
        else $error("static select moved outside power-up");
    a_static_level: assert property (staticSelect[1:0] != 2'h2 &&
        staticSelect[3:2] != 2'h2 && staticSelect[5:4] != 2'h2)
        else $error("static select holds the pin code");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer not held");
endmodule
bind dcsc_top dcsc_top_asserts #(.DYN_WIDTH(DYN_WIDTH)) i_dcsc_top_asserts (
    .core_clk(core_clk), .sys_rst(sys_rst), .dynSelectIn(dynSelectIn),
    .dynSelect(dynSelect), .refSelectIn(refSelectIn), .refSelect(refSelect),
    .syncOutputEnable(syncOutputEnable), .syncStopClocks(syncStopClocks),
    .loadUserConfig(loadUserConfig), .loadDone(loadDone),
    .userConfigReady(userConfigReady), .staticSelect(staticSelect),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

//--- tb/dcsc_top_tb.sv
// dcsc_top_tb: register, debounce, sync wait and boot tests for dcsc_top
`timescale 1ns/10ps
`default_nettype none
module dcsc_top_tb;
    localparam int          SCALE = 2;
    localparam logic [11:0] CFG   = dcsc_pkg::ADDR_DEVICE_CONFIGURATION;
    localparam logic [11:0] SYN   = dcsc_pkg::ADDR_SYNC_CONTROL;
    logic        core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, loadDone, oe, stopClk, loadReq;
    logic        cfgReady, sup2, sup3;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, refIn, refSel;
    logic [3:0]  dynIn, dynSel;
    logic [5:0]  pinLevel, staticSel;
    logic [7:0]  loadLat;
    logic [3:0]  gpiLevel;
    logic [3:0]  codes [5] = '{4'h0, 4'h1, 4'h2, 4'hC, 4'hF};
    int          n_mismatch = 0, checked = 0, cycles = 0;
    int          lowCnt = 0, lastLow = 0, nStops = 0;

    dcsc_top #(.DYN_WIDTH(4), .SYNC_SCALE(SCALE)) i_dcsc_top (
        .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .gpioIn(5'h00), .gpiIn(gpiLevel), .dynSelectIn(dynIn),
        .refSelectIn(refIn), .staticPinLevel(pinLevel), .loadDone(loadDone),
        .dynSelect(dynSel), .refSelect(refSel), .syncOutputEnable(oe),
        .syncStopClocks(stopClk), .loadUserConfig(loadReq), .userConfigReady(cfgReady),
        .staticSelect(staticSel), .inputSupply2Float(sup2), .inputSupply3Float(sup3)
    );
    dcsc_board_model i_dcsc_board_model (
        .core_clk(core_clk), .sys_rst(sys_rst), .loadLatency(loadLat),
        .loadUserConfig(loadReq), .loadDone(loadDone)
    );
    // ----
    // clock, watchdog, disable-length monitor
    // ----
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        cycles <= cycles + 1;
        if (stopClk === 1'b1) lastLow <= lowCnt;
        nStops <= nStops + 32'(stopClk === 1'b1);
        lowCnt <= (oe === 1'b0) ? lowCnt + 1 : 0;
        if (cycles == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ----
    // tasks
    // ----
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic hsA, hsW, hsB;
        logic [1:0] r;
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge core_clk);
            hsA = awvalid && awready === 1'b1;
            hsW = wvalid && wready === 1'b1;
            hsB = bvalid === 1'b1;
            r   = bresp;
            @(posedge core_clk);
            if (hsA) awvalid <= 1'b0;
            if (hsW) wvalid <= 1'b0;
            if (hsB) bready <= 1'b0;
        end while (!hsB);
        check(32'(r), 32'(er), "write response");
    endtask
    task automatic rd_check(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic hsA, hsB;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge core_clk);
            hsA = arvalid && arready === 1'b1;
            hsB = rvalid === 1'b1;
            d   = rdata;
            r   = rresp;
            @(posedge core_clk);
            if (hsA) arvalid <= 1'b0;
            if (hsB) rready <= 1'b0;
        end while (!hsB);
        check(d, ed, "read data");
        check(32'(r), 32'(er), "read response");
    endtask
    function automatic logic [31:0] seen(input logic dyn);
        return dyn ? 32'(dynSel) : 32'(refSel);
    endfunction
    task automatic drive(input logic dyn, input logic [3:0] v);
        if (dyn) dynIn <= v;
        else refIn <= v[1:0];
    endtask
    // first pass is a glitch one sample short, second pass holds the value
    task automatic deb_test(input logic dyn, input int target, input logic [3:0] val);
        logic [3:0] old;
        old = dyn ? dynIn : {2'h0, refIn};
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            drive(dyn, val);
            repeat (target - 1) @(posedge core_clk);
            if (k == 0) drive(dyn, old);
            #1;
            check(seen(dyn), 32'(old), "select before interval");
            repeat (target + 3) @(posedge core_clk);
            #1;
            check(seen(dyn), k ? 32'(val) : 32'(old), "select after interval");
        end
    endtask
    task automatic sync_test(input logic [3:0] code);
        int exp, n0;
        exp = SCALE << ((code > 4'hC) ? 12 : code);
        n0  = nStops;
        wr(CFG, {12'h001, code, 16'hF02A}, 2'h0);
        wr(SYN, 32'h0000_0001, 2'h0);
        if (code >= 4'hC) begin
            rd_check(SYN, 32'h0000_0001, 2'h0);
            wr(SYN, 32'h0000_0001, 2'h0);
        end
        for (int i = 0; i < 20000 && nStops == n0; i++) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        check(32'(lastLow >= exp && lastLow <= exp + 2), 32'h1, "disable wait");
        check(32'(oe), 32'h1, "output enable back");
    endtask
    task automatic wait_ready();
        for (int i = 0; i < 200 && cfgReady !== 1'b1; i++) @(negedge core_clk);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        sys_rst  = 1'b1;
        awaddr   = 12'h000;
        araddr   = 12'h000;
        wdata    = 32'h0000_0000;
        dynIn    = 4'h0;
        refIn    = 2'h0;
        pinLevel = 6'h37;
        loadLat  = 8'h01;
        gpiLevel = 4'h0;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_check(CFG, 32'h0012_F02A, 2'h0);
        wr(CFG, 32'h0012_6007, 2'h0);
        repeat (4) @(negedge core_clk);
        check(32'({loadReq, cfgReady}), 32'h0, "power-good wait");
        @(posedge core_clk);
        gpiLevel <= 4'h2;
        wait_ready();
        check(32'(cfgReady), 32'h1, "boot done");
        check(32'(staticSel), 32'h07, "static select");
        rd_check(dcsc_pkg::ADDR_SELECT_STATUS, 32'h0000_81C0, 2'h0);
        wr(CFG, 32'hFFFF_FFFF, 2'h0);
        rd_check(CFG, 32'h7FFF_FFFF, 2'h0);
        check(32'({sup3, sup2}), 32'h3, "supply float");
        wr(12'h00C, 32'h0000_0000, 2'h2);
        rd_check(12'h00C, 32'h0000_0000, 2'h2);
        // power-good pin is no dynamic select, so no inversion to manage
        for (int c = 0; c < 4; c++) begin
            wr(CFG, {10'h000, 2'(c), 20'h2F02A}, 2'h0);
            deb_test(1'b0, 2 * c + 2, 4'((c + 1) % 4));
        end
        for (int c = 0; c < 2; c++) begin
            wr(CFG, {9'h000, 1'(c), 22'h12F02A}, 2'h0);
            deb_test(1'b1, c ? 256 : 8, c ? 4'h5 : 4'hA);
        end
        foreach (codes[i]) sync_test(codes[i]);
        @(posedge core_clk);
        loadLat  <= 8'h20;
        pinLevel <= 6'h1D;
        sys_rst  <= 1'b1;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_check(CFG, 32'h0012_F02A, 2'h0);
        wr(CFG, 32'h0012_F02A, 2'h0);
        @(negedge core_clk);
        check(32'({loadReq, cfgReady}), 32'h2, "slow load pending");
        wait_ready();
        check(32'(staticSel), 32'h1D, "static select");
        finish_test();
    end
endmodule
`default_nettype wire
